// [hw/tpc_gr_unit.sv]
// one general register with its pin: compare output or input capture
`timescale 1ns/10ps
`default_nettype none
module tpc_gr_unit import tpc_pkg::*; (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // function field and channel state
  input  wire logic          io_wr,
  input  wire tpc_io_t       io_wdata,
  input  wire logic          run,
  input  wire logic          blocked,
  // counter, software and buffer loads
  input  wire logic [CW-1:0] count,
  input  wire logic          gr_wr,
  input  wire logic [CW-1:0] gr_wdata,
  input  wire logic          buf_ld,
  input  wire logic [CW-1:0] buf_val,
  // pin
  input  wire logic          pin_in,
  output logic               pin_out,
  output logic               pin_oe,
  // state and events
  output tpc_io_t            code,
  output logic [CW-1:0]      gr,
  output tpc_evt_t           evt
);
  logic          pin_prev;
  logic          io_seen;
  tpc_io_t       next_code;
  logic [CW-1:0] next_gr;
  logic          next_pin;

  wire rise      = pin_in & ~pin_prev;
  wire fall      = ~pin_in & pin_prev;
  // both edges when act bit 1 set
  wire edge_hit  = code.act[1] ? (rise | fall) : (code.act[0] ? fall : rise);
  wire cap       = code.capture & ~blocked & edge_hit;
  wire match     = ~code.capture & ~blocked & run & (count == gr);
  // new initial level only while halted
  wire init_pin  = io_wr & ~run & ~io_wdata.capture & (io_wdata.act != ACT_KEEP);
  wire match_pin = (code.act == ACT_LOW)    ? 1'b0 :
                   (code.act == ACT_HIGH)   ? 1'b1 :
                   (code.act == ACT_TOGGLE) ? ~pin_out : pin_out;

  assign evt       = '{match: match, capture: cap};
  assign next_code = io_wr ? io_wdata : code;
  // pin only moves on match or a halted initial-level write, so a halt alone keeps it
  assign next_pin  = init_pin ? io_wdata.init_high : (match ? match_pin : pin_out);
  assign next_gr   = gr_wr ? gr_wdata : (cap ? count : (buf_ld ? buf_val : gr));

  // reset leaves the pin driven low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code     <= IO_RST;
      gr       <= GR_RST;
      pin_out  <= 1'b0;
      pin_oe   <= 1'b1;
      pin_prev <= 1'b0;
      io_seen  <= 1'b0;
    end else begin
      code     <= next_code;
      gr       <= next_gr;
      pin_out  <= next_pin;
      pin_oe   <= ~next_code.capture & ~blocked;
      pin_prev <= pin_in;
      io_seen  <= io_seen | io_wr;
    end
  end

  property p_match_low;
    @(posedge clk) disable iff (!resetn) match && code.act == ACT_LOW |=> !pin_out;
  endproperty
  a_match_low: assert property (p_match_low) else $error("match did not drive low");

  property p_match_high;
    @(posedge clk) disable iff (!resetn) match && code.act == ACT_HIGH |=> pin_out;
  endproperty
  a_match_high: assert property (p_match_high) else $error("match did not drive high");

  property p_toggle;
    @(posedge clk) disable iff (!resetn) match && code.act == ACT_TOGGLE |=> pin_out != $past(pin_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match did not toggle");

  property p_reset_low;
    @(posedge clk) disable iff (!resetn) !io_seen && !blocked |-> !pin_out && pin_oe;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("pin not low before setup");

  property p_rise;
    @(posedge clk) disable iff (!resetn)
      code.capture && !blocked && code.act == 2'h0 |-> evt.capture == rise;
  endproperty
  a_rise: assert property (p_rise) else $error("rising capture wrong");

  property p_fall;
    @(posedge clk) disable iff (!resetn)
      code.capture && !blocked && code.act == 2'h1 |-> evt.capture == fall;
  endproperty
  a_fall: assert property (p_fall) else $error("falling capture wrong");

  property p_both;
    @(posedge clk) disable iff (!resetn)
      code.capture && !blocked && code.act[1] && (rise || fall) |-> evt.capture;
  endproperty
  a_both: assert property (p_both) else $error("both edge capture missed");

  property p_blocked;
    @(posedge clk) disable iff (!resetn) blocked |-> !evt.match && !evt.capture;
  endproperty
  a_blocked: assert property (p_blocked) else $error("event while buffered");

  property p_halt_hold;
    @(posedge clk) disable iff (!resetn) !run && !io_wr |=> pin_out == $past(pin_out);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("pin moved while halted");

  property p_init;
    @(posedge clk) disable iff (!resetn) init_pin |=> pin_out == $past(io_wdata.init_high);
  endproperty
  a_init: assert property (p_init) else $error("initial level not applied");

  property p_capture;
    @(posedge clk) disable iff (!resetn) cap && !gr_wr |=> gr == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost counter value");
endmodule : tpc_gr_unit
`default_nettype wire

// [hw/tpc_timer.sv]
// five channel timer: pin functions, start control, counters, requests
//
// Function
// - bits 0x01 give compare, match drives low
// - codes 0010/0110 set initial, match drives high
// - codes 0011/0111 set initial, match toggles pin
// - pin outputs low after reset until configured
// - top bit set, low 00 captures rising
// - top bit set, low 01 captures falling
// - top bit set, bit 1 captures both edges
// - channel 3 buffer mode silences register D
// - start bits 7,6 run channels 4,3
// - start bits 2..0 run channels 2..0
// - halting keeps last compare pin level
// - field write while halted sets initial level
// - start register reserved bits read zero
// - DMA request on match, capture, ch4 wrap
// - converter trigger on A, E, ch4 trough
// - interrupt sources 7,4,4,5,5 per channel
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tpc_timer import tpc_pkg::*; (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RESETN,
  // register port
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic [DW-1:0]      RDATA,
  // timer pins
  input  wire logic [NPIN-1:0] PIN_IN,
  output logic [NPIN-1:0]      PIN_OUT,
  output logic [NPIN-1:0]      PIN_OE,
  // requests
  output logic [NCH-1:0]     DMA_REQ,
  output logic               ADC_START,
  output logic               IRQ
);
  // offset of an address from a base, and whether it lands in n slots
  function automatic logic [AW-1:0] offs(input logic [AW-1:0] a, input logic [AW-1:0] base);
    offs = a - base;
  endfunction : offs

  function automatic logic in_win(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                  input logic [AW-1:0] n);
    in_win = (a >= base) && (offs(a, base) < n);
  endfunction : in_win

  logic [7:0]      start;
  logic [7:0]      mode;
  logic [NIRQ-1:0] irq_stat;
  logic [NIRQ-1:0] irq_mask;
  logic [CW-1:0]   gr_e0;
  logic [CW-1:0]   cnt     [NCH];
  logic [NCH-1:0]  ovf;
  logic [NCH-1:0]  unf;
  logic [NCH-1:0]  run;
  tpc_evt_t        evt     [NPIN];
  tpc_io_t         code    [NPIN];
  logic [CW-1:0]   grv     [NPIN];
  logic [NPIN-1:0] mc;
  logic [NPIN-1:0] pin_q;
  logic [NPIN-1:0] oe_q;
  logic [7:0]      io_rd   [2*NCH];
  logic [NCH-1:0]  next_dma;
  logic [NIRQ-1:0] irq_evt;
  logic [NIRQ-1:0] next_stat;

  // address decode
  wire             wr_start = WR && ADDR == ADDR_START;
  wire             wr_mode  = WR && ADDR == ADDR_MODE;
  wire             wr_stat  = WR && ADDR == ADDR_IRQ_STAT;
  wire             wr_mask  = WR && ADDR == ADDR_IRQ_MASK;
  wire             wr_e0    = WR && ADDR == ADDR_GR_E0;
  wire             io_hit   = in_win(ADDR, ADDR_IO_BASE, 8'(2 * NCH));
  wire             cnt_hit  = in_win(ADDR, ADDR_CNT_BASE, 8'(NCH));
  wire             gr_hit   = in_win(ADDR, ADDR_GR_BASE, 8'(NPIN));
  wire [AW-1:0]    io_idx   = offs(ADDR, ADDR_IO_BASE);
  wire [AW-1:0]    cnt_idx  = offs(ADDR, ADDR_CNT_BASE);
  wire [AW-1:0]    gr_idx   = offs(ADDR, ADDR_GR_BASE);
  wire             buf_mode = mode[MODE_BUF_POS];
  wire             e_match  = run[0] && cnt[0] == gr_e0;

  genvar ch;
  genvar r;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic [CW-1:0] next_cnt;
      wire           down   = mode[ch];
      wire           cnt_wr = WR && cnt_hit && cnt_idx == 8'(ch);
      // start bit runs or halts the counter
      assign run[ch]   = start[RUN_POS[ch]];
      assign ovf[ch]   = run[ch] && !cnt_wr && !down && cnt[ch] == CNT_MAX;
      assign unf[ch]   = run[ch] && !cnt_wr && down && cnt[ch] == '0;
      assign next_cnt  = cnt_wr ? WDATA[CW-1:0] :
                         !run[ch] ? cnt[ch] :
                         down ? cnt[ch] - 16'h0001 : cnt[ch] + 16'h0001;
      // any A to D register event of the channel asks for DMA; the E match does not
      assign next_dma[ch] = (|mc[ch*NGR +: NGR]) | ((ch == 4) ? (ovf[ch] | unf[ch]) : 1'b0);
      assign io_rd[2*ch]   = {code[ch*NGR+1], code[ch*NGR]};
      assign io_rd[2*ch+1] = {code[ch*NGR+3], code[ch*NGR+2]};

      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          cnt[ch] <= GR_RST;
        end else begin
          cnt[ch] <= next_cnt;
        end
      end

      // channels 0 to 4 count the same way
      property p_count;
        @(posedge CLK) disable iff (!RESETN)
          run[ch] && !cnt_wr && !down |=> cnt[ch] == $past(cnt[ch]) + 16'h0001;
      endproperty
      a_count: assert property (p_count) else $error("running counter did not step");

      property p_stop;
        @(posedge CLK) disable iff (!RESETN) !run[ch] && !cnt_wr |=> $stable(cnt[ch]);
      endproperty
      a_stop: assert property (p_stop) else $error("halted counter moved");

      for (r = 0; r < NGR; r++) begin : g_gr
        localparam int K = ch * NGR + r;
        if (r < 2 || ch == 0 || ch > 2) begin : g_unit
          wire       io_wr = WR && io_hit && io_idx == 8'(2 * ch + r / 2);
          wire       gr_wr = WR && gr_hit && gr_idx == 8'(K);
          wire       blk   = (K == BUF_GR_D) && buf_mode;
          wire       ld    = buf_mode && ((K == BUF_GR_B) ? evt[BUF_GR_B].match :
                                          (K == BUF_GR_D) ? evt[BUF_GR_B].capture : 1'b0);
          wire [CW-1:0] lv = (K == BUF_GR_B) ? grv[BUF_GR_D] : grv[BUF_GR_B];
          tpc_gr_unit u_gr (
            .clk      (CLK),
            .resetn   (RESETN),
            .io_wr    (io_wr),
            .io_wdata (tpc_io_t'(WDATA[(r % 2) * 4 +: 4])),
            .run      (run[ch]),
            .blocked  (blk),
            .count    (cnt[ch]),
            .gr_wr    (gr_wr),
            .gr_wdata (WDATA[CW-1:0]),
            .buf_ld   (ld),
            .buf_val  (lv),
            .pin_in   (PIN_IN[K]),
            .pin_out  (pin_q[K]),
            .pin_oe   (oe_q[K]),
            .code     (code[K]),
            .gr       (grv[K]),
            .evt      (evt[K])
          );
        end else begin : g_none
          // channels 1 and 2 have no C and D registers
          assign pin_q[K] = 1'b0;
          assign oe_q[K]  = 1'b0;
          assign code[K]  = IO_RST;
          assign grv[K]   = GR_RST;
          assign evt[K]   = '{match: 1'b0, capture: 1'b0};
        end
        assign mc[K] = evt[K].match | evt[K].capture;
      end
    end
  endgenerate

  assign PIN_OUT = pin_q;
  assign PIN_OE  = oe_q;

  // interrupt source layout, channel 4 merges wrap events
  assign irq_evt = {ovf[4] | unf[4], mc[19:16], ovf[3], mc[15:12],
                    unf[2], ovf[2], mc[9:8], unf[1], ovf[1], mc[5:4],
                    unf[0], ovf[0], e_match, mc[3:0]};
  // event wins over a same-cycle write-one clear
  assign next_stat = (irq_stat & ~(wr_stat ? WDATA[NIRQ-1:0] : IRQ_RST)) | irq_evt;
  // mask seen by the level must be the one stored at the same edge
  wire [NIRQ-1:0] next_mask = wr_mask ? WDATA[NIRQ-1:0] : irq_mask;

  // converter trigger from A events, E match and ch4 trough
  wire next_adc = mc[0] | mc[4] | mc[8] | mc[12] | mc[16] | e_match | unf[4];

  // read selection; unmapped addresses read zero
  wire [DW-1:0] rd_mux =
    (ADDR == ADDR_START)    ? DW'(start) :
    (ADDR == ADDR_MODE)     ? DW'(mode) :
    (ADDR == ADDR_IRQ_STAT) ? DW'(irq_stat) :
    (ADDR == ADDR_IRQ_MASK) ? DW'(irq_mask) :
    (ADDR == ADDR_GR_E0)    ? DW'(gr_e0) :
    io_hit  ? DW'(io_rd[io_idx[3:0]]) :
    cnt_hit ? DW'(cnt[cnt_idx[2:0]]) :
    gr_hit  ? DW'(grv[gr_idx[4:0]]) : '0;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      start     <= START_RST;
      mode      <= MODE_RST;
      irq_stat  <= IRQ_RST;
      irq_mask  <= IRQ_RST;
      gr_e0     <= GR_RST;
      RDATA     <= '0;
      DMA_REQ   <= '0;
      ADC_START <= 1'b0;
      IRQ       <= 1'b0;
    end else begin
      if (wr_start) start <= WDATA[7:0] & START_MASK;
      // mode changes assume software halted the counter
      if (wr_mode) mode <= WDATA[7:0];
      if (wr_mask) irq_mask <= WDATA[NIRQ-1:0];
      if (wr_e0) gr_e0 <= WDATA[CW-1:0];
      irq_stat  <= next_stat;
      RDATA     <= RD ? rd_mux : '0;
      DMA_REQ   <= next_dma;
      ADC_START <= next_adc;
      IRQ       <= |(next_stat & next_mask);
    end
  end

  property p_rsvd;
    @(posedge CLK) disable iff (!RESETN) RD && ADDR == ADDR_START |=> RDATA[5:3] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved start bits read set");

  property p_dma4;
    @(posedge CLK) disable iff (!RESETN) ovf[4] || unf[4] || mc[19:16] != '0 |=> DMA_REQ[4];
  endproperty
  a_dma4: assert property (p_dma4) else $error("channel 4 DMA request missing");

  property p_adc;
    @(posedge CLK) disable iff (!RESETN) mc[0] || e_match || unf[4] |=> ADC_START;
  endproperty
  a_adc: assert property (p_adc) else $error("converter trigger missing");

  property p_irq;
    @(posedge CLK) disable iff (!RESETN) IRQ == |(irq_stat & irq_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level mismatch");

  property p_sticky;
    @(posedge CLK) disable iff (!RESETN) ovf[1] |=> irq_stat[9] throughout (!wr_stat [*1]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag lost");
endmodule : tpc_timer
`default_nettype wire

// [inc/tpc_pkg.sv]
// shared constants and types for the timer pin and start control block
package tpc_pkg;
  localparam int NCH  = 5;
  localparam int NGR  = 4;
  localparam int NPIN = NCH * NGR;
  localparam int CW   = 16;
  localparam int AW   = 8;
  localparam int DW   = 32;
  localparam int NIRQ = 25;

  // register offsets
  localparam logic [AW-1:0] ADDR_START    = 8'h00;
  localparam logic [AW-1:0] ADDR_MODE     = 8'h01;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h02;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h03;
  localparam logic [AW-1:0] ADDR_IO_BASE  = 8'h10;
  localparam logic [AW-1:0] ADDR_CNT_BASE = 8'h20;
  localparam logic [AW-1:0] ADDR_GR_BASE  = 8'h30;
  localparam logic [AW-1:0] ADDR_GR_E0    = 8'h50;

  // field positions and reset values
  localparam logic [7:0]      START_MASK   = 8'hC7;
  localparam logic [7:0]      START_RST    = 8'h00;
  localparam logic [7:0]      MODE_RST     = 8'h00;
  localparam int              MODE_BUF_POS = 7;
  localparam int              RUN_POS [NCH] = '{0, 1, 2, 6, 7};
  localparam logic [3:0]      IO_RST       = 4'h0;
  localparam logic [CW-1:0]   GR_RST       = 16'h0000;
  localparam logic [CW-1:0]   CNT_MAX      = 16'hFFFF;
  localparam logic [NIRQ-1:0] IRQ_RST      = 25'h0000000;
  localparam int              BUF_GR_B     = 3 * NGR + 1;
  localparam int              BUF_GR_D     = 3 * NGR + 3;

  // pin action on compare match, low two bits of a field
  localparam logic [1:0] ACT_KEEP   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // pin function field: capture, initial level, action or edge
  typedef struct packed {
    logic       capture;
    logic       init_high;
    logic [1:0] act;
  } tpc_io_t;

  typedef struct packed {
    logic match;
    logic capture;
  } tpc_evt_t;
endpackage : tpc_pkg

// [tb/timer_pin_io_and_start_control_test.sv]
// self-checking bench for the timer pin and start control block
`timescale 1ns/10ps
`default_nettype none
module timer_pin_io_and_start_control_test import tpc_pkg::*;;
  localparam logic [3:0] CMP_CODES [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h0, 4'h4};
  localparam logic [3:0] CAP_CODES [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE};
  logic            clk    = 1'b0;
  logic            resetn = 1'b0;
  logic [AW-1:0]   addr   = '0;
  logic [DW-1:0]   wdata  = '0;
  logic            wr     = 1'b0;
  logic            rd     = 1'b0;
  logic [NPIN-1:0] drv    = '0;
  logic [DW-1:0]   rdata;
  wire  [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] pin_oe;
  logic [NCH-1:0]  dma;
  logic            adc;
  logic            irq;
  logic [DW-1:0]   v;
  logic [3:0]      code;
  logic            lvl;
  logic            hit;
  int              n_mismatch = 0;
  int              cmp_count  = 0;
  int              n_dma [NCH] = '{default: 0};
  int              n_adc = 0;
  int              d0;
  int              a0;

  always #2.5 clk = ~clk;

  tpc_timer i_dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .DMA_REQ(dma),
    .ADC_START(adc), .IRQ(irq));
  tpc_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .drv(drv), .pin_in(pin_in));

  // pulses are one cycle, so counting them at each edge catches every event
  always @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (dma[i] === 1'b1) n_dma[i] <= n_dma[i] + 1;
    end
    if (adc === 1'b1) n_adc <= n_adc + 1;
  end

  task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg

  task automatic creg(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    rreg(a, d);
    chk(nm, d, e);
  endtask : creg

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // whole run is under 600 cycles; this leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    idle(1);
    chk("pins after reset", pin_out, '0);
    creg("start reset", ADDR_START, 32'h0);
    wreg(ADDR_START, 32'hFF);
    creg("start reserved", ADDR_START, 32'hC7);
    creg("unmapped", 8'h7F, 32'h0);
    wreg(ADDR_START, 32'h0);
    // one run bit at a time must move exactly its own counter
    for (int c = 0; c < NCH; c++) begin
      for (int j = 0; j < NCH; j++) wreg(ADDR_CNT_BASE + AW'(j), 32'h0);
      wreg(ADDR_START, DW'(1) << RUN_POS[c]);
      idle(4);
      wreg(ADDR_START, 32'h0);
      for (int j = 0; j < NCH; j++) begin
        rreg(ADDR_CNT_BASE + AW'(j), v);
        chk("counter runs", DW'(v != 0), DW'(j == c));
      end
      rreg(ADDR_CNT_BASE + AW'(c), v);
      idle(3);
      creg("counter halted", ADDR_CNT_BASE + AW'(c), v);
    end
    wreg(ADDR_IRQ_STAT, 32'h1FFFFFF);
    // compare codes on channel 0 register A, level tracked across codes
    wreg(ADDR_GR_BASE, 32'h5);
    lvl = 1'b0;
    for (int i = 0; i < 8; i++) begin
      code = CMP_CODES[i];
      d0 = n_dma[0];
      a0 = n_adc;
      wreg(ADDR_CNT_BASE, 32'h3);
      wreg(ADDR_IO_BASE, {28'h0, code});
      idle(2);
      if (code[1:0] != ACT_KEEP) lvl = code[2];
      chk("initial level", pin_out[0], lvl);
      chk("compare oe", pin_oe[0], 1'b1);
      wreg(ADDR_START, 32'h1);
      idle(8);
      wreg(ADDR_START, 32'h0);
      idle(2);
      case (code[1:0])
        ACT_LOW: lvl = 1'b0;
        ACT_HIGH: lvl = 1'b1;
        ACT_TOGGLE: lvl = ~lvl;
        default: lvl = lvl;
      endcase
      chk("match level", pin_out[0], lvl);
      idle(4);
      chk("halt keeps level", pin_out[0], lvl);
      chk("match dma", DW'(n_dma[0] - d0), 32'h1);
      chk("match adc", DW'(n_adc - a0), 32'h1);
    end
    creg("status", ADDR_IRQ_STAT, 32'h1);
    chk("irq masked", irq, 1'b0);
    wreg(ADDR_IRQ_MASK, 32'h1);
    idle(2);
    chk("irq raised", irq, 1'b1);
    wreg(ADDR_IRQ_STAT, 32'h1);
    idle(2);
    chk("irq cleared", irq, 1'b0);
    creg("status cleared", ADDR_IRQ_STAT, 32'h0);
    // capture on channel 1 register A, halted counter holds a known value
    for (int i = 0; i < 6; i++) begin
      code = CAP_CODES[i];
      wreg(ADDR_IO_BASE + 8'h2, {28'h0, code});
      wreg(ADDR_CNT_BASE + 8'h1, DW'(32'h100 + i));
      for (int e = 1; e >= 0; e--) begin
        wreg(ADDR_GR_BASE + 8'h4, 32'h0);
        d0 = n_dma[1];
        drv[4] <= e[0];
        idle(4);
        hit = code[1] | (code[0] == ~e[0]);
        rreg(ADDR_GR_BASE + 8'h4, v);
        chk("capture value", v, hit ? DW'(32'h100 + i) : 32'h0);
        chk("capture dma", DW'(n_dma[1] - d0), DW'(hit));
      end
    end
    // channel 3 register D, plain then as buffer
    wreg(ADDR_IO_BASE + 8'h7, 32'h50);
    idle(2);
    chk("d initial", pin_out[15], 1'b1);
    creg("pin ctl low", ADDR_IO_BASE + 8'h7, 32'h50);
    // counters are all halted before the mode changes
    wreg(ADDR_MODE, 32'h80);
    wreg(ADDR_IO_BASE + 8'h7, 32'h30);
    idle(2);
    chk("buffered d oe", pin_oe[15], 1'b0);
    // channel 4 down count through zero
    wreg(ADDR_MODE, 32'h10);
    for (int r = 0; r < NGR; r++) wreg(ADDR_GR_BASE + 8'h10 + AW'(r), 32'h100);
    wreg(ADDR_CNT_BASE + 8'h4, 32'h2);
    wreg(ADDR_IRQ_STAT, 32'h1FFFFFF);
    d0 = n_dma[4];
    a0 = n_adc;
    wreg(ADDR_START, 32'h80);
    idle(6);
    wreg(ADDR_START, 32'h0);
    idle(2);
    chk("wrap dma", DW'(n_dma[4] - d0), 32'h1);
    chk("trough adc", DW'(n_adc - a0), 32'h1);
    creg("wrap status", ADDR_IRQ_STAT, 32'h1000000);
    tally_and_finish();
  end
endmodule : timer_pin_io_and_start_control_test
`default_nettype wire

// [tb/tpc_pin_model.sv]
// outside circuits on the timer pins
`timescale 1ns/10ps
`default_nettype none
module tpc_pin_model import tpc_pkg::*; (
  // timer side
  input  wire logic [NPIN-1:0] pin_out,
  input  wire logic [NPIN-1:0] pin_oe,
  // level the outside driver wants
  input  wire logic [NPIN-1:0] drv,
  // resolved level back into the timer
  output logic      [NPIN-1:0] pin_in
);
  // outside drive backs off while the timer drives, so no contention
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule : tpc_pin_model
`default_nettype wire
